// ### rtl/bfc_map.svh
// bfc_map.svh: register offsets, field positions, reset values and timing constants
// assumes: included by its bare name from the fan commutator design files
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH

// ==========================================================================
// register map (byte addresses on the plain register port)
`define BFC_ADDR_W 4
`define BFC_OFS_CTRL 4'h0
`define BFC_OFS_STATUS 4'h4
`define BFC_OFS_DUTY 4'h8

// ==========================================================================
// control register fields and reset values
`define BFC_CTRL_DIV_LSB 0
`define BFC_CTRL_DIV_W 8
`define BFC_CTRL_DIV_RESET 8'h04

// ==========================================================================
// status register fields
`define BFC_ST_HALL_LSB 0
`define BFC_ST_DIR_BIT 3
`define BFC_ST_RUN_BIT 4
`define BFC_ST_UV_BIT 5
`define BFC_ST_OT_BIT 6
`define BFC_ST_ILIM_BIT 7
`define BFC_ST_PROT_BIT 8

// ==========================================================================
// timing and duty constants
`define BFC_CLK_FREQ_KHZ 40000
`define BFC_PWM_MAX_FREQ_KHZ 40
`define BFC_ZERO_DUTY_CODE 8'h10
`define BFC_FULL_DUTY_CODE 8'hF0

`endif

// ### rtl/bfc_pkg.sv
// bfc_pkg.sv: types shared by the fan commutator design files
// assumes: nothing beyond a SystemVerilog compiler
package bfc_pkg;

  // ==========================================================================
  // run state machine, one-hot
  typedef enum logic [2:0] {
    BFC_ST_STOP = 3'b001,
    BFC_ST_RUN = 3'b010,
    BFC_ST_PROTECT = 3'b100
  } bfc_state_e;

  // per-phase drive vector, bit 0 = phase a, bit 2 = phase c
  typedef logic [2:0] bfc_phase_t;

endpackage : bfc_pkg

// ### rtl/bfc_sync.sv
// bfc_sync.sv: three-stage synchroniser with agreement filter for pin inputs
// assumes: inputs are asynchronous levels; a change is taken once stage two and three agree
`timescale 1ns/1ps

module bfc_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ==========================================================================
  // per-bit synchroniser and agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // stage1 is read only by stage2
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          stage1[i] <= RESET_VAL[i];
          stage2[i] <= RESET_VAL[i];
          stage3[i] <= RESET_VAL[i];
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
        end
      end

      // a new level counts only when two samples agree, rejecting single-cycle noise
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          level_out[i] <= RESET_VAL[i];
        end else if (stage2[i] == stage3[i]) begin
          level_out[i] <= stage3[i];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // checks
  property p_sync_agree;
    @(posedge ref_clk) disable iff (reset)
      (level_out != $past(level_out)) |-> ($past(stage2) == $past(stage3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("filtered level changed without agreement");

endmodule : bfc_sync

// ### rtl/bfc_core.sv
// bfc_core.sv: digital control of a three-phase brushless fan driver
// assumes: hall, run/stop, direction and protection inputs are comparator levels from pins;
// the speed command arrives as an 8-bit code from a converter on ref_clk
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bfc_map.svh"

module bfc_core #(
  parameter logic [7:0] ZERO_DUTY_CODE = `BFC_ZERO_DUTY_CODE,
  parameter logic [7:0] FULL_DUTY_CODE = `BFC_FULL_DUTY_CODE
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] speed_command_input,
  input wire logic hall_channel_a,
  input wire logic hall_channel_b,
  input wire logic hall_channel_c,
  input wire logic run_stop,
  input wire logic direction,
  input wire logic undervoltage,
  input wire logic overtemp,
  input wire logic current_sense_input,
  input wire logic [`BFC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic phase_output_a_high,
  output logic phase_output_b_high,
  output logic phase_output_c_high,
  output logic phase_output_a_low,
  output logic phase_output_b_low,
  output logic phase_output_c_low,
  output logic speed_pulse_single,
  output logic speed_pulse_triple
);

  // ==========================================================================
  // derived timing: shortest carrier period in cycles, rounded up, and the divider floor
  localparam int PWM_STEPS = 256;
  localparam int MIN_PERIOD_CYC = (`BFC_CLK_FREQ_KHZ + `BFC_PWM_MAX_FREQ_KHZ - 1) / `BFC_PWM_MAX_FREQ_KHZ;
  localparam int MIN_DIV_INT = (MIN_PERIOD_CYC + PWM_STEPS - 1) / PWM_STEPS;
  localparam logic [7:0] MIN_DIV = 8'(MIN_DIV_INT);

  // ==========================================================================
  // pin synchronisers; stop and reverse idle high, matching a floating pin
  localparam logic [7:0] SYNC_RESET = 8'h18;
  logic [7:0] sync_raw;
  logic [7:0] sync_lvl;
  logic hall_a_s;
  logic hall_b_s;
  logic hall_c_s;
  logic stop_s;
  logic reverse_s;
  logic uv_s;
  logic ot_s;
  logic ilim_s;

  assign sync_raw = {current_sense_input, overtemp, undervoltage, direction, run_stop,
                     hall_channel_c, hall_channel_b, hall_channel_a};

  bfc_sync #(
    .WIDTH(8),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(sync_raw),
    .level_out(sync_lvl)
  );

  // split the filtered levels
  assign hall_a_s = sync_lvl[0];
  assign hall_b_s = sync_lvl[1];
  assign hall_c_s = sync_lvl[2];
  assign stop_s = sync_lvl[3];
  assign reverse_s = sync_lvl[4];
  assign uv_s = sync_lvl[5];
  assign ot_s = sync_lvl[6];
  assign ilim_s = sync_lvl[7];

  // ==========================================================================
  // registers
  logic [7:0] carrier_div;
  logic [7:0] div_eff;
  logic ilim_hold;
  logic [7:0] duty_eff;
  bfc_pkg::bfc_state_e state;
  bfc_pkg::bfc_state_e next_state;

  // software write of the carrier divider
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      carrier_div <= `BFC_CTRL_DIV_RESET;
    end else if (reg_wr && reg_addr == `BFC_OFS_CTRL) begin
      carrier_div <= reg_wdata[`BFC_CTRL_DIV_LSB +: `BFC_CTRL_DIV_W];
    end
  end

  // divider floor keeps the carrier at or below its maximum frequency
  assign div_eff = (carrier_div < MIN_DIV) ? MIN_DIV : carrier_div;

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `BFC_OFS_CTRL: reg_rdata <= {24'h00_0000, carrier_div};
        `BFC_OFS_STATUS: begin
          reg_rdata <= {23'h00_0000, state == bfc_pkg::BFC_ST_PROTECT, ilim_s | ilim_hold, ot_s, uv_s,
                        state == bfc_pkg::BFC_ST_RUN, reverse_s, hall_c_s, hall_b_s, hall_a_s};
        end
        `BFC_OFS_DUTY: reg_rdata <= {24'h00_0000, duty_eff};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // carrier: step enable from the divider, 8-bit ramp
  logic [7:0] div_cnt;
  logic step_en;
  logic [7:0] pwm_cnt;
  logic period_start;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_cnt <= 8'h00;
      step_en <= 1'b0;
    end else if (div_cnt >= div_eff - 8'h01) begin
      div_cnt <= 8'h00;
      step_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      step_en <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwm_cnt <= 8'h00;
    end else if (step_en) begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  assign period_start = step_en && pwm_cnt == 8'hFF;

  // ==========================================================================
  // duty mapping: dead band at the bottom gives 0%, saturation at the top gives 100%
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      duty_eff <= 8'h00;
    end else if (speed_command_input <= ZERO_DUTY_CODE) begin
      duty_eff <= 8'h00;
    end else if (speed_command_input >= FULL_DUTY_CODE) begin
      duty_eff <= 8'hFF;
    end else begin
      duty_eff <= speed_command_input;
    end
  end

  logic pwm_on;
  // 8'hFF means always on, so the full span reaches 100%
  assign pwm_on = (duty_eff == 8'hFF) || (pwm_cnt < duty_eff);

  // ==========================================================================
  // current limiter: trip holds the high side off until the next period; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ilim_hold <= 1'b0;
    end else if (ilim_s) begin
      ilim_hold <= 1'b1;
    end else if (period_start) begin
      ilim_hold <= 1'b0;
    end
  end

  // ==========================================================================
  // run state machine
  always_comb begin
    next_state = state;
    case (state)
      bfc_pkg::BFC_ST_STOP: begin
        if (uv_s || ot_s) begin
          next_state = bfc_pkg::BFC_ST_PROTECT;
        end else if (!stop_s) begin
          next_state = bfc_pkg::BFC_ST_RUN;
        end
      end
      bfc_pkg::BFC_ST_RUN: begin
        if (uv_s || ot_s) begin
          next_state = bfc_pkg::BFC_ST_PROTECT;
        end else if (stop_s) begin
          next_state = bfc_pkg::BFC_ST_STOP;
        end
      end
      bfc_pkg::BFC_ST_PROTECT: begin
        if (!uv_s && !ot_s) begin
          next_state = bfc_pkg::BFC_ST_STOP;
        end
      end
      default: next_state = bfc_pkg::BFC_ST_STOP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= bfc_pkg::BFC_ST_STOP;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // hall decode: six states, one high and one low phase each; reverse swaps them
  logic [2:0] hall_code;
  bfc_pkg::bfc_phase_t dec_high;
  bfc_pkg::bfc_phase_t dec_low;
  bfc_pkg::bfc_phase_t next_high;
  bfc_pkg::bfc_phase_t next_low;
  logic hall_valid;

  assign hall_code = {hall_c_s, hall_b_s, hall_a_s};
  assign hall_valid = hall_code != 3'b000 && hall_code != 3'b111;

  always_comb begin
    dec_high = 3'b000;
    dec_low = 3'b000;
    case (hall_code)
      3'b101: begin dec_high = 3'b001; dec_low = 3'b010; end
      3'b100: begin dec_high = 3'b001; dec_low = 3'b100; end
      3'b110: begin dec_high = 3'b010; dec_low = 3'b100; end
      3'b010: begin dec_high = 3'b010; dec_low = 3'b001; end
      3'b011: begin dec_high = 3'b100; dec_low = 3'b001; end
      3'b001: begin dec_high = 3'b100; dec_low = 3'b010; end
      default: begin dec_high = 3'b000; dec_low = 3'b000; end
    endcase
  end

  logic gate_off;
  // any protection or stop kills the high side whatever the pwm does
  assign gate_off = uv_s || ot_s || stop_s || ilim_s || ilim_hold ||
                    state != bfc_pkg::BFC_ST_RUN;

  always_comb begin
    if (reverse_s) begin
      next_high = dec_low;
      next_low = dec_high;
    end else begin
      next_high = dec_high;
      next_low = dec_low;
    end
    if (gate_off || !pwm_on) begin
      next_high = 3'b000;
    end
  end

  // low side follows commutation alone, so a current trip leaves the short brake in place
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {phase_output_c_high, phase_output_b_high, phase_output_a_high} <= 3'b000;
      {phase_output_c_low, phase_output_b_low, phase_output_a_low} <= 3'b000;
    end else begin
      {phase_output_c_high, phase_output_b_high, phase_output_a_high} <= next_high;
      {phase_output_c_low, phase_output_b_low, phase_output_a_low} <= next_low;
    end
  end

  // ==========================================================================
  // speed pulses: hall a level, and parity of all three halls at three times its rate
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      speed_pulse_single <= 1'b0;
      speed_pulse_triple <= 1'b0;
    end else begin
      speed_pulse_single <= hall_a_s;
      speed_pulse_triple <= hall_a_s ^ hall_b_s ^ hall_c_s;
    end
  end

  // ==========================================================================
  // checks
  logic [2:0] high_o;
  logic [2:0] low_o;
  assign high_o = {phase_output_c_high, phase_output_b_high, phase_output_a_high};
  assign low_o = {phase_output_c_low, phase_output_b_low, phase_output_a_low};

  property p_zero_duty;
    @(posedge ref_clk) disable iff (reset) (duty_eff == 8'h00) |=> (high_o == 3'b000);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("high side on at zero duty");

  property p_full_on;
    @(posedge ref_clk) disable iff (reset)
      (duty_eff == 8'hFF && !gate_off && hall_valid) |=> $onehot(high_o);
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty not driving high side");

  property p_high_single;
    @(posedge ref_clk) disable iff (reset) $onehot0(high_o) && ((high_o & low_o) == 3'b000);
  endproperty
  a_high_single: assert property (p_high_single) else $error("phase drive overlap");

  property p_carrier_floor;
    @(posedge ref_clk) disable iff (reset) step_en |=> !step_en [*3];
  endproperty
  a_carrier_floor: assert property (p_carrier_floor) else $error("carrier steps too fast");

  property p_uv_off;
    @(posedge ref_clk) disable iff (reset) uv_s |=> high_o == 3'b000;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("high side on in undervoltage");

  property p_ot_off;
    @(posedge ref_clk) disable iff (reset) ot_s |=> high_o == 3'b000;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("high side on in overtemperature");

  property p_ilim_hold;
    @(posedge ref_clk) disable iff (reset) (ilim_s ##1 !period_start) |=> high_o == 3'b000;
  endproperty
  a_ilim_hold: assert property (p_ilim_hold) else $error("high side on after current trip");

  property p_stop_off;
    @(posedge ref_clk) disable iff (reset) stop_s |=> (high_o == 3'b000 && state != bfc_pkg::BFC_ST_RUN);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop did not hold high side off");

  property p_brake_low;
    @(posedge ref_clk) disable iff (reset) (ilim_s && hall_valid) |=> $onehot(low_o);
  endproperty
  a_brake_low: assert property (p_brake_low) else $error("low side dropped during current trip");

  property p_reverse;
    @(posedge ref_clk) disable iff (reset) (reverse_s && hall_code == 3'b101) |=> low_o == 3'b001;
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse decode wrong");

  property p_fg_single;
    @(posedge ref_clk) disable iff (reset) ##1 speed_pulse_single == $past(hall_a_s);
  endproperty
  a_fg_single: assert property (p_fg_single) else $error("single speed pulse mismatch");

  property p_fg_triple;
    @(posedge ref_clk) disable iff (reset) $changed(hall_b_s) && $stable(hall_a_s) && $stable(hall_c_s)
      |=> $changed(speed_pulse_triple);
  endproperty
  a_fg_triple: assert property (p_fg_triple) else $error("triple speed pulse missed a hall edge");

  c_run: cover property (@(posedge ref_clk) state == bfc_pkg::BFC_ST_STOP ##1 state == bfc_pkg::BFC_ST_RUN);
  c_protect: cover property (@(posedge ref_clk) state == bfc_pkg::BFC_ST_PROTECT);
  c_ilim: cover property (@(posedge ref_clk) ilim_hold && period_start);
  c_chop: cover property (@(posedge ref_clk) high_o != 3'b000 ##1 high_o == 3'b000);

endmodule : bfc_core

// ### tb/bfc_motor_model.sv
// bfc_motor_model.sv: hall sensors and coils of a three-phase fan motor
// assumes: bench steps or loads the rotor on ref_clk; coil drives come from the core outputs
`timescale 1ns/1ps

module bfc_motor_model (
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [2:0] load_code,
  input wire logic step,
  input wire logic [2:0] coil_high,
  input wire logic [2:0] coil_low,
  output logic hall_a,
  output logic hall_b,
  output logic hall_c,
  output logic shoot_through
);
  // ==========================================================================
  // rotor position as hall code {c,b,a}; a step moves one forward sector
  logic [2:0] code = 3'h5;
  always @(posedge ref_clk) begin
    if (load) begin
      code <= load_code;
    end else if (step) begin
      case (code)
        3'h5: code <= 3'h4;
        3'h4: code <= 3'h6;
        3'h6: code <= 3'h2;
        3'h2: code <= 3'h3;
        3'h3: code <= 3'h1;
        default: code <= 3'h5;
      endcase
    end
  end
  assign {hall_c, hall_b, hall_a} = code;

  // ==========================================================================
  // latches any phase with both switches on, which would short the supply
  initial shoot_through = 1'b0;
  always @(posedge ref_clk) begin
    if (|(coil_high & coil_low) === 1'b1) begin
      shoot_through <= 1'b1;
    end
  end
endmodule : bfc_motor_model

// ### tb/tb_top.sv
// tb_top.sv: self-checking bench for the fan commutator core
// assumes: bfc_core and bfc_motor_model compiled first; 40 MHz ref_clk
`timescale 1ns/1ps
`include "bfc_map.svh"

module tb_top;
  // ==========================================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] speed = 8'hF0;
  logic run_stop = 1'b1;
  logic direction = 1'b0;
  logic undervoltage = 1'b0;
  logic overtemp = 1'b0;
  logic current_sense = 1'b0;
  logic [`BFC_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic load = 1'b0;
  logic step = 1'b0;
  logic [2:0] load_code = 3'h5;
  wire [31:0] reg_rdata;
  wire [2:0] high;
  wire [2:0] low;
  wire single;
  wire triple;
  wire hall_a;
  wire hall_b;
  wire hall_c;
  wire shoot;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // rows as nibbles: hall {c,b,a}, reverse, high {c,b,a}, low {c,b,a}
  logic [15:0] rows [14] = '{16'h5012, 16'h4014, 16'h6024, 16'h2021, 16'h3041, 16'h1042, 16'h0000,
                             16'h7000, 16'h5121, 16'h4141, 16'h6142, 16'h2112, 16'h3114, 16'h1124};
  // duty rows: code, duty register, carrier rises and on cycles per 2048 cycles
  logic [31:0] duty_rows [4] = '{32'h1000_0000, 32'h1111_2088, 32'h8080_2400, 32'hF0FF_0800};

  always #12.5 ref_clk = ~ref_clk;

  bfc_core i_dut (
    .ref_clk(ref_clk), .reset(reset), .speed_command_input(speed),
    .hall_channel_a(hall_a), .hall_channel_b(hall_b), .hall_channel_c(hall_c),
    .run_stop(run_stop), .direction(direction), .undervoltage(undervoltage), .overtemp(overtemp),
    .current_sense_input(current_sense), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phase_output_a_high(high[0]), .phase_output_b_high(high[1]), .phase_output_c_high(high[2]),
    .phase_output_a_low(low[0]), .phase_output_b_low(low[1]), .phase_output_c_low(low[2]),
    .speed_pulse_single(single), .speed_pulse_triple(triple)
  );

  bfc_motor_model i_motor (
    .ref_clk(ref_clk), .load(load), .load_code(load_code), .step(step), .coil_high(high),
    .coil_low(low), .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c), .shoot_through(shoot)
  );

  // ==========================================================================
  // shared tasks
  task automatic end_of_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic reg_write(logic [`BFC_ADDR_W-1:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic rd_check(string name, logic [`BFC_ADDR_W-1:0] a, logic [31:0] mask, logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(name, reg_rdata & mask, exp);
  endtask : rd_check

  // direction moves only while stopped, so no phase sees both switches on
  task automatic set_dir(logic d);
    @(posedge ref_clk);
    run_stop <= 1'b1;
    tick(8);
    direction <= d;
    tick(8);
    run_stop <= 1'b0;
    tick(8);
  endtask : set_dir

  task automatic set_hall(logic [2:0] h);
    @(posedge ref_clk);
    load <= 1'b1;
    load_code <= h;
    @(posedge ref_clk);
    load <= 1'b0;
    tick(8);
    #1;
  endtask : set_hall

  task automatic window(output int on_c, output int rises);
    logic prev;
    on_c = 0;
    rises = 0;
    prev = high[0];
    repeat (2048) begin
      @(posedge ref_clk);
      #1;
      if (high[0] === 1'b1) on_c++;
      if (high[0] === 1'b1 && prev === 1'b0) rises++;
      prev = high[0];
    end
  endtask : window

  // ==========================================================================
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    int on_c;
    int rises;
    int n_s;
    int n_t;
    logic prev_s;
    logic prev_t;
    logic steady;
    tick(5);
    reset <= 1'b0;
    tick(8);
    run_stop <= 1'b0;
    tick(8);
    // commutation table at full duty
    foreach (rows[i]) begin
      if (rows[i][8] !== direction) set_dir(rows[i][8]);
      set_hall(rows[i][14:12]);
      check("high", high, rows[i][6:4]);
      check("low", low, rows[i][2:0]);
      check("single", single, rows[i][12]);
      check("triple", triple, ^rows[i][14:12]);
    end
    set_dir(1'b0);
    set_hall(3'h5);
    // one-cycle glitch on hall a is ignored
    @(posedge ref_clk);
    load <= 1'b1;
    load_code <= 3'h4;
    @(posedge ref_clk);
    load_code <= 3'h5;
    @(posedge ref_clk);
    load <= 1'b0;
    steady = 1'b1;
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      if (single !== 1'b1) steady = 1'b0;
    end
    check("glitch", steady, 1'b1);
    // two forward revolutions: toggles of both speed pulses
    n_s = 0;
    n_t = 0;
    prev_s = single;
    prev_t = triple;
    for (int i = 0; i < 110; i++) begin
      @(posedge ref_clk);
      step <= (i < 96 && i % 8 == 0);
      #1;
      if (single !== prev_s) n_s++;
      if (triple !== prev_t) n_t++;
      prev_s = single;
      prev_t = triple;
    end
    check("single toggles", n_s, 4);
    check("triple toggles", n_t, 12);
    // stop and restart
    @(posedge ref_clk);
    run_stop <= 1'b1;
    tick(8);
    #1;
    check("stop high", high, 3'h0);
    check("stop low", low, 3'h2);
    @(posedge ref_clk);
    run_stop <= 1'b0;
    tick(8);
    #1;
    check("start high", high, 3'h1);
    // undervoltage, then overtemperature
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      {overtemp, undervoltage} <= 2'(1 << k);
      tick(8);
      #1;
      check("fault high", high, 3'h0);
      rd_check("fault status", `BFC_OFS_STATUS, 32'h0000_0170, 32'h0000_0100 | (32'h0000_0020 << k));
      @(posedge ref_clk);
      {overtemp, undervoltage} <= 2'h0;
      tick(16);
      #1;
      check("recover high", high, 3'h1);
    end
    // current trip while braking in reverse
    set_dir(1'b1);
    @(posedge ref_clk);
    current_sense <= 1'b1;
    tick(8);
    #1;
    check("trip high", high, 3'h0);
    check("trip low", low, 3'h1);
    rd_check("status", `BFC_OFS_STATUS, 32'h0000_019F, 32'h0000_009D);
    @(posedge ref_clk);
    current_sense <= 1'b0;
    for (int j = 0; j < 1100 && high !== 3'h2; j++) begin
      @(posedge ref_clk);
      #1;
    end
    check("trip release", high, 3'h2);
    set_dir(1'b0);
    // duty span and carrier rate
    foreach (duty_rows[i]) begin
      @(posedge ref_clk);
      speed <= duty_rows[i][31:24];
      tick(1100);
      window(on_c, rises);
      check("on cycles", on_c, duty_rows[i][11:0]);
      check("carrier rises", rises, duty_rows[i][15:12]);
      check("low steady", low, 3'h2);
      rd_check("duty", `BFC_OFS_DUTY, 32'h0000_00FF, duty_rows[i][23:16]);
    end
    @(posedge ref_clk);
    speed <= 8'h80;
    reg_write(`BFC_OFS_CTRL, 32'h0000_0002);
    tick(1100);
    window(on_c, rises);
    check("fast divider rises", rises, 2);
    reg_write(`BFC_OFS_CTRL, 32'h0000_0008);
    tick(1100);
    window(on_c, rises);
    check("slow divider rises", rises, 1);
    check("slow divider on", on_c, 1024);
    // second reset in mid-run
    @(posedge ref_clk);
    reset <= 1'b1;
    tick(3);
    #1;
    check("reset outputs", {high, low, single, triple}, 8'h00);
    @(posedge ref_clk);
    reset <= 1'b0;
    rd_check("ctrl reset", `BFC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0004);
    rd_check("unmapped", 4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    check("shoot through", shoot, 1'b0);
    end_of_test();
  end
endmodule : tb_top
